/* File: bench/vfd_multiplex_blanking_tb.sv */
// Self-checking bench for the tube multiplex and blanking engine
`timescale 1ns/10ps
module vfd_multiplex_blanking_tb;
  import vfd_scan_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  // One sixteenth in sys_clk cycles: osc ticks times 800 ns over 100 ns
  localparam int UNIT = SIXTEENTH_OSC * 8;
  logic sys_clk, srst, base_timing_clock, shutdown_req, reg_wr_en, reg_rd_en;
  logic [6:0] reg_addr;
  logic [7:0] reg_wr_data, reg_rd_data, pat_data, shown;
  logic pat_valid, pat_ready, tube_shift_clock, tube_serial_out, tube_latch_load;
  logic tube_blank_out, en, ll_q, sc_q, so_q, seen_en;
  logic dis_lvl = 1'b1;
  logic [5:0] grid_index, cur_idx, prev_idx;
  logic [7:0] exp_idx;
  int mismatches = 0;
  int checked = 0;
  int en_c, lead_c, last_en, last_lead, gap, last_gap, cyc, last_rise;
  int n_latch = 0;
  int idx_chk = 0;
  int viol = 0;
  int last_bits, k, n;
  logic [7:0] codes [3] = '{8'h00, 8'h0e, 8'h0f};
  int units [3] = '{1, 15, 15};
  assign en = (tube_blank_out !== dis_lvl);
  vfd_multiplex_blanking #(.PAT_WIDTH(8), .PAT_DEPTH(32)) u_dut (
    .sys_clk(sys_clk), .srst(srst), .base_timing_clock(base_timing_clock),
    .shutdown_req(shutdown_req), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .pat_valid(pat_valid), .pat_ready(pat_ready), .pat_data(pat_data),
    .grid_index(grid_index), .tube_shift_clock(tube_shift_clock),
    .tube_serial_out(tube_serial_out), .tube_latch_load(tube_latch_load),
    .tube_blank_out(tube_blank_out));
  vfd_tube_driver_model u_tube (.tube_shift_clock(tube_shift_clock),
    .tube_serial_out(tube_serial_out), .tube_latch_load(tube_latch_load),
    .shown(shown), .last_bits(last_bits));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Odd offset keeps the oscillator out of phase with sys_clk
  initial begin
    base_timing_clock = 1'b0;
    #37;
    forever #400 base_timing_clock = ~base_timing_clock;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_near(input string what, input int exp, input int got, input int tol);
    checked++;
    if (got < exp - tol || got > exp + tol) begin
      mismatches++;
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string what);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    chk8(what, exp, reg_rd_data);
    @(negedge sys_clk);
  endtask
  // Bounded, since a stalled scan must not hang the run
  task automatic wait_latch;
    int c0;
    c0 = n_latch;
    for (int i = 0; i < 4000 && n_latch == c0; i++) @(negedge sys_clk);
    chk_near("latch_pulse", c0 + 1, n_latch, 0);
    // The tube model takes its pattern as the load falls, so wait for that too
    for (int i = 0; i < 100 && tube_latch_load !== 1'b0; i++) @(negedge sys_clk);
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // Slot monitor
  // ----------------------------------------
  always @(posedge sys_clk) begin
    cyc++;
    if (tube_latch_load && !ll_q) begin
      last_en = en_c;
      last_lead = lead_c;
      last_gap = gap;
      en_c = 0;
      lead_c = 0;
      seen_en = 1'b0;
      n_latch++;
      exp_idx = (prev_idx == 6'd2) ? 8'h00 : {2'b00, prev_idx + 6'd1};
      if (idx_chk == 1) chk8("grid_index", exp_idx, {2'b00, cur_idx});
      if (idx_chk == 2) idx_chk = 1;
      prev_idx = cur_idx;
    end else if (en) begin
      en_c++;
      seen_en = 1'b1;
    end else if (!seen_en) lead_c++;
    if (lead_c == 100) cur_idx = grid_index;
    if (tube_shift_clock && !sc_q) begin
      gap = cyc - last_rise;
      last_rise = cyc;
    end
    if (!srst && tube_shift_clock === 1'b1 && tube_serial_out !== so_q) viol++;
    ll_q = tube_latch_load;
    sc_q = tube_shift_clock;
    so_q = tube_serial_out;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    give_verdict;
  end
  initial begin
    srst = 1'b1;
    shutdown_req = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 7'h00;
    reg_wr_data = 8'h00;
    pat_valid = 1'b0;
    pat_data = 8'h00;
    repeat (8) @(negedge sys_clk);
    chk8("blank_level", 8'h01, {7'h00, tube_blank_out});
    srst = 1'b0;
    @(negedge sys_clk);
    rd(ADDR_BLANK_POL, 8'h00, "blank_polarity_select");
    rd(ADDR_BRIGHT, 8'h00, "brightness_level");
    rd(ADDR_GRIDS, 8'h00, "grid_count");
    rd(ADDR_TEST, {DEVICE_ID, 1'b0}, "test_mode_flag");
    rd(ADDR_SHIFT_LIM, SHIFT_MAX, "shift_limit");
    rd(7'h10, 8'h00, "unmapped");
    wr(ADDR_GRIDS, 8'h30);
    rd(ADDR_GRIDS, GRID_MAX, "grid_count");
    wr(ADDR_GRIDS, 8'hff);
    rd(ADDR_GRIDS, GRID_MAX, "grid_count");
    wr(ADDR_GRIDS, 8'h2f);
    rd(ADDR_GRIDS, 8'h2f, "grid_count");
    wr(ADDR_GRIDS, 8'h02);
    wr(ADDR_BRIGHT, 8'hf3);
    wr(ADDR_NOOP, 8'hff);
    rd(ADDR_GRIDS, 8'h02, "grid_count");
    rd(ADDR_BRIGHT, 8'h03, "brightness_level");
    rd(ADDR_BLANK_POL, 8'h00, "blank_polarity_select");
    wait_latch;
    wait_latch;
    chk_near("enabled_time", 0, last_en, 8);
    wait_latch;
    chk_near("enabled_time", 4 * UNIT, last_en, 8);
    chk_near("leading_blank", UNIT, last_lead, 8);
    chk_near("shift_bits", 84, last_bits, 0);
    chk_near("shift_period", 32, last_gap, 1);
    idx_chk = 2;
    for (k = 0; k < 3; k++) begin
      wr(ADDR_BRIGHT, codes[k]);
      wait_latch;
      wait_latch;
      chk_near("enabled_time", units[k] * UNIT, last_en, 8);
      chk_near("leading_blank", UNIT, last_lead, 8);
    end
    idx_chk = 0;
    shutdown_req = 1'b1;
    repeat (4) @(negedge sys_clk);
    n = 0;
    repeat (3300) begin
      @(negedge sys_clk);
      if (en) n++;
    end
    chk_near("shutdown_enabled", 0, n, 0);
    shutdown_req = 1'b0;
    wait_latch;
    wait_latch;
    chk_near("enabled_time", 0, last_en, 8);
    wait_latch;
    chk_near("enabled_time", 15 * UNIT, last_en, 8);
    wr(ADDR_BLANK_POL, 8'h02);
    dis_lvl = 1'b0;
    rd(ADDR_BLANK_POL, 8'h02, "blank_polarity_select");
    wr(ADDR_TEST, 8'h01);
    rd(ADDR_TEST, {DEVICE_ID, 1'b1}, "test_mode_flag");
    wait_latch;
    wait_latch;
    chk_near("enabled_time", 7 * UNIT, last_en, 8);
    chk8("latched_pattern", 8'hff, shown);
    wr(ADDR_TEST, 8'h00);
    wr(ADDR_BLANK_POL, 8'h00);
    dis_lvl = 1'b1;
    wr(ADDR_SHIFT_LIM, 8'hff);
    rd(ADDR_SHIFT_LIM, SHIFT_MAX, "shift_limit");
    wr(ADDR_SHIFT_LIM, 8'h3f);
    wait_latch;
    wait_latch;
    // Filled right after a load, well before the shifter pulls its first byte
    n = 0;
    pat_valid = 1'b1;
    for (k = 0; k < 40; k++) begin
      pat_data = 8'(k + 1);
      if (pat_ready !== 1'b1) break;
      n++;
      @(negedge sys_clk);
    end
    pat_valid = 1'b0;
    chk_near("fifo_accepted", 32, n, 0);
    for (k = 1; k <= 5; k++) begin
      wait_latch;
      chk8("latched_pattern", (k < 5) ? 8'(8 * k) : 8'h00, shown);
    end
    chk_near("shift_bits", 64, last_bits, 0);
    chk_near("data_change_at_high_clock", 0, viol, 0);
    give_verdict;
  end
endmodule

/* File: bench/vfd_tube_driver_model.sv */
// Behavioural high-voltage tube driver: serial shift register and output latch
`timescale 1ns/10ps
module vfd_tube_driver_model (
  input wire logic tube_shift_clock,
  input wire logic tube_serial_out,
  input wire logic tube_latch_load,
  output logic [7:0] shown,
  output int last_bits
);
  // ----------------------------------------
  // Shift chain and latch
  // ----------------------------------------
  // Only the last eight bits are kept; the full chain would only add width
  logic [7:0] sr = 8'h00;
  int shifted = 0;
  int base = 0;
  // Data is taken on the rising clock edge, half a bit after it changed
  always @(posedge tube_shift_clock) begin
    sr <= {tube_serial_out, sr[7:1]};
    shifted <= shifted + 1;
  end
  // Latch is transparent while high, so the fall fixes the shown pattern
  always @(negedge tube_latch_load) begin
    shown <= sr;
    last_bits <= shifted - base;
    base <= shifted;
  end
endmodule

/* File: core/vfd_multiplex_blanking.sv */
// Tube multiplex scan, serial shift and blanking engine with its pattern FIFO
`timescale 1ns/10ps
// ----------------------------------------
// Pattern FIFO
// ----------------------------------------
module vfd_pattern_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ----------------------------------------
// Engine
// ----------------------------------------
module vfd_multiplex_blanking
#(
  parameter int PAT_WIDTH = 8,
  parameter int PAT_DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic base_timing_clock,
  input wire logic shutdown_req,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  input wire logic pat_valid,
  output logic pat_ready,
  input wire logic [PAT_WIDTH-1:0] pat_data,
  output logic [5:0] grid_index,
  output logic tube_shift_clock,
  output logic tube_serial_out,
  output logic tube_latch_load,
  output logic tube_blank_out
);
  import vfd_scan_pkg::*;
  localparam int BW = $clog2(PAT_WIDTH);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] grid_count_q;
  logic [3:0] brightness_q;
  logic pol_q;
  logic test_mode_flag_q;
  logic [7:0] shift_limit_q;
  logic [7:0] rd_data_q;

  wire wr_grids = reg_wr_en && (reg_addr == ADDR_GRIDS);
  wire wr_bright = reg_wr_en && (reg_addr == ADDR_BRIGHT);
  wire wr_pol = reg_wr_en && (reg_addr == ADDR_BLANK_POL);
  wire wr_test = reg_wr_en && (reg_addr == ADDR_TEST);
  wire wr_limit = reg_wr_en && (reg_addr == ADDR_SHIFT_LIM);
  wire [7:0] grid_wdata = (reg_wr_data > GRID_MAX) ? GRID_MAX : reg_wr_data;
  wire [7:0] limit_wdata = (reg_wr_data > SHIFT_MAX) ? SHIFT_MAX : reg_wr_data;
  // The no-op address has no decode term, so its writes fall through
  wire [7:0] rd_mux =
    (reg_addr == ADDR_BLANK_POL) ? {6'h00, pol_q, 1'b0} :
    (reg_addr == ADDR_BRIGHT) ? {4'h0, brightness_q} :
    (reg_addr == ADDR_GRIDS) ? grid_count_q :
    (reg_addr == ADDR_TEST) ? {DEVICE_ID, test_mode_flag_q} :
    (reg_addr == ADDR_SHIFT_LIM) ? shift_limit_q : 8'h00;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      grid_count_q <= RST_GRIDS;
      brightness_q <= RST_BRIGHT;
      pol_q <= RST_POL;
      test_mode_flag_q <= 1'b0;
      shift_limit_q <= RST_SHIFT_LIM;
      rd_data_q <= 8'h00;
    end else begin
      if (wr_grids) begin
        grid_count_q <= grid_wdata;
      end
      if (wr_bright) begin
        brightness_q <= reg_wr_data[3:0];
      end
      if (wr_pol) begin
        pol_q <= reg_wr_data[POL_BIT];
      end
      if (wr_test) begin
        test_mode_flag_q <= reg_wr_data[TEST_BIT];
      end
      if (wr_limit) begin
        shift_limit_q <= limit_wdata;
      end
      if (reg_rd_en) begin
        rd_data_q <= rd_mux;
      end
    end
  end
  assign reg_rd_data = rd_data_q;

  // ----------------------------------------
  // Base clock edge detection
  // ----------------------------------------
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= base_timing_clock;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end
  wire osc_tick = osc_s2_q && !osc_s3_q;

  // ----------------------------------------
  // Slot timing: sixteen units per grid
  // ----------------------------------------
  logic [5:0] sub_q;
  logic [3:0] unit_q;
  logic [5:0] grid_q;
  wire sub_end = (sub_q == 6'(SIXTEENTH_OSC - 1));
  wire slot_end = osc_tick && sub_end && (unit_q == 4'(SLOT_UNITS - 1));
  wire [5:0] last_grid = grid_count_q[5:0];
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sub_q <= '0;
      unit_q <= '0;
      grid_q <= '0;
    end else if (osc_tick) begin
      sub_q <= sub_end ? 6'h00 : sub_q + 6'h01;
      if (sub_end) begin
        unit_q <= unit_q + 4'h1;
      end
      if (slot_end) begin
        grid_q <= (grid_q >= last_grid) ? 6'h00 : grid_q + 6'h01;
      end
    end
  end
  assign grid_index = grid_q;
  // slot_start is the first system cycle of a new grid's cycle
  logic slot_start_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      slot_start_q <= 1'b0;
    end else begin
      slot_start_q <= slot_end;
    end
  end

  // ----------------------------------------
  // Latch load
  // ----------------------------------------
  logic latch_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      latch_q <= 1'b0;
    end else if (slot_start_q) begin
      latch_q <= 1'b1;
    end else if (osc_tick && sub_q == 6'h01) begin
      latch_q <= 1'b0;
    end
  end
  assign tube_latch_load = latch_q;

  // ----------------------------------------
  // Serial shifter for the next grid
  // ----------------------------------------
  // Shifting starts after the latch pulse so the load never sees a half pattern
  logic shifting_q;
  logic [1:0] phase_q;
  logic [6:0] bit_q;
  logic [PAT_WIDTH-1:0] byte_q;
  logic sclk_q;
  logic sdo_q;
  logic fifo_valid;
  logic [PAT_WIDTH-1:0] fifo_data;
  wire shift_go = osc_tick && sub_end && (unit_q == 4'(SHIFT_START_UNIT - 1));
  wire phase_tick = osc_tick && shifting_q;
  wire bit_first = phase_tick && (phase_q == 2'd0);
  wire need_byte = bit_first && (bit_q[BW-1:0] == '0);
  wire last_bit = (bit_q >= shift_limit_q[6:0]);
  wire fresh_bit = fifo_valid ? fifo_data[0] : 1'b0;
  wire next_bit = test_mode_flag_q ? 1'b1 : (need_byte ? fresh_bit : byte_q[0]);

  vfd_pattern_fifo #(
    .WIDTH(PAT_WIDTH),
    .DEPTH(PAT_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(pat_valid),
    .in_ready(pat_ready),
    .in_data(pat_data),
    .out_valid(fifo_valid),
    .out_ready(need_byte),
    .out_data(fifo_data)
  );

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      shifting_q <= 1'b0;
      phase_q <= '0;
      bit_q <= '0;
      byte_q <= '0;
      sclk_q <= 1'b0;
      sdo_q <= 1'b0;
    end else if (shift_go) begin
      shifting_q <= 1'b1;
      phase_q <= '0;
      bit_q <= '0;
    end else if (phase_tick) begin
      phase_q <= phase_q + 2'd1;
      if (phase_q == 2'd0) begin
        sclk_q <= 1'b0;
        sdo_q <= next_bit;
        byte_q <= (need_byte ? (fifo_valid ? fifo_data : '0) : byte_q) >> 1;
      end
      if (phase_q == 2'd2) begin
        sclk_q <= 1'b1;
      end
      if (phase_q == 2'(SHIFT_DIV - 1)) begin
        bit_q <= bit_q + 7'd1;
        if (last_bit) begin
          shifting_q <= 1'b0;
        end
      end
    end
  end
  assign tube_shift_clock = sclk_q;
  assign tube_serial_out = sdo_q;

  // ----------------------------------------
  // Blanking and brightness
  // ----------------------------------------
  logic pend_q;
  logic stale_q;
  logic shut_d1_q;
  logic blank_q;
  wire shut_exit = shut_d1_q && !shutdown_req;
  wire stale_evt = wr_grids || shut_exit;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      shut_d1_q <= 1'b0;
      pend_q <= 1'b0;
      stale_q <= 1'b0;
    end else begin
      shut_d1_q <= shutdown_req;
      if (slot_end) begin
        stale_q <= pend_q;
      end
      // A fresh event in the boundary cycle keeps the request pending
      pend_q <= stale_evt || (pend_q && !slot_end);
    end
  end
  // Codes 14 and 15 both reach the end of the slot
  wire [3:0] code = test_mode_flag_q ? TEST_CODE :
    (brightness_q > TOP_CODE ? TOP_CODE : brightness_q);
  wire [4:0] on_units = 5'(code) + 5'd1;
  wire pwm_on = (unit_q != 4'h0) && (5'(unit_q) <= on_units);
  wire hold_off = shutdown_req || pend_q || stale_q || !pwm_on;
  wire dis_lvl = !pol_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      blank_q <= 1'b1;
    end else begin
      blank_q <= hold_off ? dis_lvl : !dis_lvl;
    end
  end
  assign tube_blank_out = blank_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  AST_GRID_CLAMP: assert property (
    wr_grids && reg_wr_data >= 8'h30 |=> grid_count_q == GRID_MAX)
    else $error("Grid count not clamped");
  AST_GRID_WRAP: assert property (
    slot_end && grid_q >= last_grid |=> grid_q == 6'h00)
    else $error("Grid index did not wrap");
  AST_GRID_STEP: assert property (
    slot_end && grid_q < last_grid |=> grid_q == $past(grid_q) + 6'h01)
    else $error("Grid index did not step");
  AST_LATCH_PULSE: assert property (
    slot_start_q |=> tube_latch_load)
    else $error("No latch load at cycle start");
  AST_LEAD_BLANK: assert property (
    unit_q == 4'h0 |=> tube_blank_out == $past(dis_lvl))
    else $error("Leading sixteenth not blanked");
  AST_SHUT_BLANK: assert property (
    shutdown_req |=> tube_blank_out == $past(dis_lvl))
    else $error("Tube enabled during shutdown");
  AST_SHIFT_DONE: assert property (
    slot_end |-> !shifting_q)
    else $error("Shift still running at cycle end");
  AST_BRIGHT_NIBBLE: assert property (
    wr_bright |=> brightness_q == $past(reg_wr_data[3:0]))
    else $error("Brightness nibble wrong");
  AST_TEST_DUTY: assert property (
    test_mode_flag_q && unit_q == 4'h8 && !wr_test |=> tube_blank_out == $past(dis_lvl))
    else $error("Test duty exceeds 7/16");
  AST_STALE_BLANK: assert property (
    stale_q |=> tube_blank_out == $past(dis_lvl))
    else $error("Stale cycle not blanked");
  COV_WRAP: cover property (slot_end && grid_q == last_grid && last_grid != 6'h00);
  COV_FULL_SHIFT: cover property (phase_tick && last_bit && shift_limit_q == SHIFT_MAX);
  COV_TOP_DUTY: cover property (unit_q == 4'hf && !hold_off);
  COV_TEST: cover property (test_mode_flag_q && slot_start_q);
endmodule

/* File: core/vfd_scan_pkg.sv */
// Constants for the tube multiplex and blanking engine
package vfd_scan_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [6:0] ADDR_NOOP = 7'h00;
  localparam logic [6:0] ADDR_BLANK_POL = 7'h01;
  localparam logic [6:0] ADDR_BRIGHT = 7'h02;
  localparam logic [6:0] ADDR_GRIDS = 7'h03;
  localparam logic [6:0] ADDR_TEST = 7'h07;
  localparam logic [6:0] ADDR_SHIFT_LIM = 7'h0e;
  // ----------------------------------------
  // Fields and limits
  // ----------------------------------------
  localparam int POL_BIT = 1;
  localparam int TEST_BIT = 0;
  localparam logic [7:0] GRID_MAX = 8'h2f;
  localparam logic [7:0] SHIFT_MAX = 8'h53;
  localparam logic [3:0] TEST_CODE = 4'h6;
  localparam logic [3:0] TOP_CODE = 4'he;
  // Arbitrary neutral identity value
  localparam logic [6:0] DEVICE_ID = 7'h05;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_GRIDS = 8'h00;
  localparam logic [3:0] RST_BRIGHT = 4'h0;
  localparam logic RST_POL = 1'b0;
  localparam logic [7:0] RST_SHIFT_LIM = 8'h53;
  // ----------------------------------------
  // Timing: base clock rate in kHz, sixteenth in ns, counts in base clock periods or sixteenths
  // ----------------------------------------
  localparam int OSC_KHZ = 4000;
  localparam int SIXTEENTH_NS = 6250;
  localparam int SIXTEENTH_OSC = SIXTEENTH_NS * OSC_KHZ / 1000000;
  localparam int SLOT_UNITS = 16;
  localparam int SHIFT_DIV = 4;
  localparam int SHIFT_START_UNIT = 1;
endpackage
